// >>> design/cwf_core.sv
// configurable width fifo core with flags, write mask, read skip, mark and replay.
// assumes all pins synchronous to aclk; writer and reader share aclk.
`timescale 1ns/1ps
`default_nettype none
`include "cwf_defs.svh"
module cwf_core
    import cwf_pkg::*;
#(
    parameter int ADDR_W = 23
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`CWF_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`CWF_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic full_reset_n,
    input wire logic pointer_reset_n,
    input wire logic [2:0] width_sel,
    input wire logic wr_en_n,
    input wire logic in_en_n,
    input wire logic [`CWF_BUS_W-1:0] din,
    input wire logic rd_en_n,
    input wire logic out_en_n,
    output logic [`CWF_BUS_W-1:0] dout,
    output logic [`CWF_BUS_W-1:0] dout_oe,
    output logic out_valid_n,
    input wire logic mark,
    input wire logic replay,
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic serial_cfg_en_n,
    output logic empty_n,
    output logic almost_empty_n,
    output logic half_full_n,
    output logic almost_full_n,
    output logic full_n
);
    localparam int DEPTH = 1 << ADDR_W;
    // flag compare width: neither the count nor a 10-bit offset can wrap in it
    localparam int CW = (ADDR_W + 1 > `CWF_OFS_W ? ADDR_W + 1 : `CWF_OFS_W) + 1;

    // active lanes of the selected word width
    function automatic cwf_word_t lane_mask(input cwf_width_t w);
        unique case (w)
            3'b000: lane_mask = 36'h0000001FF;
            3'b001: lane_mask = 36'h000000FFF;
            3'b010: lane_mask = 36'h00000FFFF;
            3'b011: lane_mask = 36'h00003FFFF;
            3'b100: lane_mask = 36'h0000FFFFF;
            3'b101: lane_mask = 36'h000FFFFFF;
            3'b110: lane_mask = 36'h0FFFFFFFF;
            3'b111: lane_mask = 36'hFFFFFFFFF;
        endcase
    endfunction : lane_mask

    // selected depth: full, half or quarter of the array
    function automatic logic [ADDR_W:0] sel_depth(input cwf_width_t w);
        logic [ADDR_W:0] full_d;
        full_d = (ADDR_W + 1)'(DEPTH);
        if (w == 3'b000) begin
            sel_depth = full_d;
        end else if (!w[2]) begin
            sel_depth = full_d >> 1;
        end else begin
            sel_depth = full_d >> 2;
        end
    endfunction : sel_depth

    // next pointer value with wrap at the selected depth
    function automatic logic [ADDR_W-1:0] ptr_inc(input logic [ADDR_W-1:0] p,
                                                  input logic [ADDR_W:0] d);
        logic [ADDR_W-1:0] m;
        m = ADDR_W'(d - 1'b1);
        ptr_inc = (p + 1'b1) & m;
    endfunction : ptr_inc

    // register word hit: compares word indices, byte lanes ignored
    function automatic logic reg_hit(input logic [`CWF_AXI_AW-1:0] a,
                                     input logic [`CWF_AXI_AW-1:0] ofs);
        reg_hit = a[`CWF_AXI_AW-1:2] == ofs[`CWF_AXI_AW-1:2];
    endfunction : reg_hit

    // byte-lane merge of a bus write into an offset register
    function automatic cwf_ofs_t ofs_merge(input cwf_ofs_t cur, input logic [31:0] d,
                                           input logic [3:0] s);
        ofs_merge = cur;
        if (s[0]) begin
            ofs_merge[7:0] = d[7:0];
        end
        if (s[1]) begin
            ofs_merge[`CWF_OFS_W-1:8] = d[`CWF_OFS_W-1:8];
        end
    endfunction : ofs_merge

    cwf_word_t mem [0:DEPTH-1];
    cwf_width_t width_q;
    cwf_ofs_t ae_ofs;
    cwf_ofs_t af_ofs;
    logic [ADDR_W-1:0] wr_ptr;
    logic [ADDR_W-1:0] rd_ptr;
    logic [ADDR_W-1:0] last_rd;
    logic [ADDR_W-1:0] mark_ptr;
    logic full_reset_q;
    logic replay_q;
    logic serial_clk_q;
    logic [ADDR_W:0] depth;
    logic [ADDR_W:0] count;
    logic master_rst;
    logic ptr_rst;
    logic can_write;
    logic can_read;
    logic wr_go;
    logic rd_go;
    logic replay_go;
    logic aw_held;
    logic w_held;
    logic [`CWF_AXI_AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic reg_wr;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic ae_above;
    logic af_below;

    assign master_rst = !aresetn || !full_reset_n;
    assign ptr_rst = !pointer_reset_n;
    assign depth = sel_depth(width_q);
    assign count = {1'b0, (wr_ptr - rd_ptr) & ADDR_W'(depth - 1'b1)};
    assign can_write = count < depth - (ADDR_W + 1)'(`CWF_RESERVE);
    assign can_read = count != '0;
    assign wr_go = !wr_en_n && can_write && !master_rst && !ptr_rst;
    assign rd_go = !rd_en_n && can_read && !master_rst && !ptr_rst;
    assign replay_go = replay && !replay_q;
    assign ae_above = CW'(count) > CW'(ae_ofs);
    assign af_below = CW'(count) + CW'(af_ofs) < CW'(depth);

    // width selection caught on the release of full_reset_n; aresetn loads the default width
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            width_q <= `CWF_WIDTH_DEFAULT;
            full_reset_q <= 1'b1;
        end else begin
            full_reset_q <= full_reset_n;
            if (full_reset_n && !full_reset_q) begin
                width_q <= width_sel;
            end
        end
    end

    // offsets: serial shift has priority over bus writes
    always_ff @(posedge aclk) begin
        if (master_rst) begin
            ae_ofs <= `CWF_OFS_DEFAULT;
            af_ofs <= `CWF_OFS_DEFAULT;
            serial_clk_q <= 1'b0;
        end else begin
            serial_clk_q <= serial_clk;
            if (!serial_cfg_en_n && serial_clk && !serial_clk_q) begin
                {af_ofs, ae_ofs} <= {af_ofs[`CWF_OFS_W-2:0], ae_ofs, serial_in};
            end else if (reg_wr && reg_hit(aw_addr, `CWF_REG_AE_OFS)) begin
                ae_ofs <= ofs_merge(ae_ofs, w_data, w_strb);
            end else if (reg_wr && reg_hit(aw_addr, `CWF_REG_AF_OFS)) begin
                af_ofs <= ofs_merge(af_ofs, w_data, w_strb);
            end
        end
    end

    // storage: masked writes leave the location untouched
    always_ff @(posedge aclk) begin
        if (wr_go && !in_en_n) begin
            mem[wr_ptr] <= din & lane_mask(width_q);
        end
    end

    // write pointer
    always_ff @(posedge aclk) begin
        if (master_rst || ptr_rst) begin
            wr_ptr <= '0;
        end else if (wr_go) begin
            wr_ptr <= ptr_inc(wr_ptr, depth);
        end
    end

    // read pointer, last read location and mark
    always_ff @(posedge aclk) begin
        if (master_rst || ptr_rst) begin
            rd_ptr <= '0;
            last_rd <= '0;
            mark_ptr <= '0;
            replay_q <= 1'b0;
        end else begin
            replay_q <= replay;
            if (mark) begin
                mark_ptr <= last_rd;
            end
            if (replay_go) begin
                rd_ptr <= mark_ptr;
            end else if (rd_go) begin
                rd_ptr <= ptr_inc(rd_ptr, depth);
                last_rd <= rd_ptr;
            end
        end
    end

    // output register, lane drive and valid
    always_ff @(posedge aclk) begin
        if (master_rst || ptr_rst) begin
            dout <= '0;
            dout_oe <= '0;
            out_valid_n <= 1'b1;
        end else begin
            dout_oe <= out_en_n ? '0 : lane_mask(width_q);
            out_valid_n <= !(rd_go && !replay_go && !out_en_n);
            if (rd_go && !replay_go && !out_en_n) begin
                dout <= mem[rd_ptr] & lane_mask(width_q);
            end
        end
    end

    // flags
    always_ff @(posedge aclk) begin
        if (master_rst || ptr_rst) begin
            empty_n <= 1'b0;
            almost_empty_n <= 1'b0;
            half_full_n <= 1'b1;
            almost_full_n <= 1'b1;
            full_n <= 1'b1;
        end else begin
            empty_n <= count != '0;
            almost_empty_n <= ae_above;
            half_full_n <= count < (depth >> 1);
            almost_full_n <= af_below;
            full_n <= can_write;
        end
    end

    // bus write side: address and data taken in either order
    assign reg_wr = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CWF_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (reg_wr) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case ({aw_addr[`CWF_AXI_AW-1:2], 2'b00})
                    `CWF_REG_STATUS, `CWF_REG_AE_OFS, `CWF_REG_AF_OFS, `CWF_REG_COUNT: begin
                        s_axi_bresp <= `CWF_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `CWF_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // bus read mux
    always_comb begin
        next_rdata = '0;
        next_rresp = `CWF_RESP_OKAY;
        unique case ({s_axi_araddr[`CWF_AXI_AW-1:2], 2'b00})
            `CWF_REG_STATUS: begin
                next_rdata[4:0] = {full_n, almost_full_n, half_full_n, almost_empty_n, empty_n};
                next_rdata[7:5] = width_q;
                next_rdata[8] = out_valid_n;
            end
            `CWF_REG_AE_OFS: begin
                next_rdata[`CWF_OFS_W-1:0] = ae_ofs;
            end
            `CWF_REG_AF_OFS: begin
                next_rdata[`CWF_OFS_W-1:0] = af_ofs;
            end
            `CWF_REG_COUNT: begin
                next_rdata[ADDR_W:0] = count;
            end
            default: begin
                next_rresp = `CWF_RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `CWF_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rresp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : cwf_core
`default_nettype wire

// >>> inc/cwf_defs.svh
// constants of the configurable width fifo core: offsets, reset values, response codes.
// assumes inclusion by bare name from the package and the core.
`ifndef CWF_DEFS_SVH
`define CWF_DEFS_SVH

`define CWF_BUS_W 36
`define CWF_OFS_W 10
`define CWF_OFS_DEFAULT 10'h07F
`define CWF_RESERVE 4
`define CWF_AXI_AW 8

`define CWF_REG_STATUS 8'h00
`define CWF_REG_AE_OFS 8'h04
`define CWF_REG_AF_OFS 8'h08
`define CWF_REG_COUNT 8'h0C

`define CWF_RESP_OKAY 2'b00
`define CWF_RESP_SLVERR 2'b10

`define CWF_WIDTH_DEFAULT 3'b000

`endif

// >>> inc/cwf_pkg.sv
// types shared by the configurable width fifo core.
// assumes cwf_defs.svh is on the include path.
`include "cwf_defs.svh"
package cwf_pkg;
    typedef logic [2:0] cwf_width_t;
    typedef logic [`CWF_BUS_W-1:0] cwf_word_t;
    typedef logic [`CWF_OFS_W-1:0] cwf_ofs_t;
endpackage : cwf_pkg

// >>> tb/cwf_core_asserts.sv
// port checker of the fifo core: reset states, shown reads, lanes, flag order.
// assumes binding into cwf_core on its single aclk domain.
`timescale 1ns/1ps
`default_nettype none
`include "cwf_defs.svh"
module cwf_core_asserts
    import cwf_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic full_reset_n,
    input wire logic pointer_reset_n,
    input wire logic [2:0] width_sel,
    input wire logic rd_en_n,
    input wire logic out_en_n,
    input wire logic [`CWF_BUS_W-1:0] dout,
    input wire logic [`CWF_BUS_W-1:0] dout_oe,
    input wire logic out_valid_n,
    input wire logic empty_n,
    input wire logic almost_empty_n,
    input wire logic half_full_n,
    input wire logic almost_full_n,
    input wire logic full_n
);
    localparam int WB [8] = '{9, 12, 16, 18, 20, 24, 32, 36};
    cwf_width_t wcode;
    logic fr_q;
    cwf_word_t lanes;
    assign lanes = cwf_word_t'((37'h1 << WB[wcode]) - 37'h1);
    // width is caught on the rise of full_reset_n; aresetn loads code 0
    always_ff @(posedge aclk) begin
        fr_q <= full_reset_n;
        if (!aresetn) begin
            wcode <= 3'h0;
        end else if (full_reset_n && !fr_q) begin
            wcode <= width_sel;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !full_reset_n || !pointer_reset_n);
    mreset_state_a: assert property (disable iff (!aresetn)
        !full_reset_n |=> !empty_n && !almost_empty_n && full_n && half_full_n && almost_full_n
        && out_valid_n && dout == '0 && dout_oe == '0) else $error("master reset state wrong");
    preset_state_a: assert property (disable iff (!aresetn)
        !pointer_reset_n |=> !empty_n && !almost_empty_n && full_n && half_full_n
        && almost_full_n) else $error("pointer reset flags wrong");
    valid_cause_a: assert property (!out_valid_n |-> !$past(rd_en_n) && !$past(out_en_n))
        else $error("valid without shown read");
    skip_hiz_a: assert property ($past(out_en_n) |-> dout_oe == '0)
        else $error("outputs driven while disabled");
    dout_hold_a: assert property (out_valid_n && $past(aresetn) && $past(full_reset_n)
        && $past(pointer_reset_n) |-> $stable(dout)) else $error("data moved without read");
    lane_mask_a: assert property ((dout_oe & ~lanes) == '0)
        else $error("unused lane driven");
    half_not_empty_a: assert property (!half_full_n |-> empty_n)
        else $error("empty while half full");
    full_half_a: assert property (!full_n |-> !half_full_n)
        else $error("full without half full");
endmodule : cwf_core_asserts
bind cwf_core cwf_core_asserts u_chk (.aclk, .aresetn, .full_reset_n, .pointer_reset_n,
    .width_sel, .rd_en_n, .out_en_n, .dout, .dout_oe, .out_valid_n, .empty_n, .almost_empty_n,
    .half_full_n, .almost_full_n, .full_n);
`default_nettype wire

// >>> tb/cwf_writer.sv
// write-side partner: drives write bursts of random words into the fifo core.
// assumes aclk is the write clock and the caller enters just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "cwf_defs.svh"
module cwf_writer
    import cwf_pkg::*;
(
    input wire logic aclk,
    output logic wr_en_n,
    output logic in_en_n,
    output logic [`CWF_BUS_W-1:0] din
);
    initial begin
        wr_en_n = 1'b1;
        in_en_n = 1'b0;
        din = '0;
    end
    task automatic burst(input int n, input bit masking);
        for (int i = 0; i < n + n % 2; i++) begin
            wr_en_n <= 1'b0;
            in_en_n <= masking && $urandom_range(1) == 1;
            din <= cwf_word_t'({$urandom, $urandom});
            @(posedge aclk);
        end
        wr_en_n <= 1'b1;
        din <= ~din;
    endtask : burst
endmodule : cwf_writer
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench of the fifo core: offsets, flags, skip, mark, widths, register bus.
// assumes cwf_writer drives the write side; reads and bus cycles come from here.
`timescale 1ns/1ps
`default_nettype none
`include "cwf_defs.svh"
module tb
    import cwf_pkg::*;
;
    logic aclk = 0, aresetn = 0, full_reset_n = 0, pointer_reset_n = 1, rd_en_n = 1;
    logic out_en_n = 0, mark = 0, replay = 0, serial_clk = 0, serial_in = 0, serial_cfg_en_n = 1;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, awr, wrd, bv, arr, rv, wr_en_n, in_en_n;
    logic out_valid_n, empty_n, almost_empty_n, half_full_n, almost_full_n, full_n, rp_q, pend, ps;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat;
    logic [1:0] bresp, rresp;
    logic [9:0] ae, af;
    cwf_width_t width_sel = 0;
    cwf_word_t din, dout, dout_oe, msk, exp_q;
    cwf_word_t mem [32];
    int n_mismatch = 0, cmp_count = 0, cyc = 0, dep = 32, wp, rp, mk, rl;
    logic wok;
    always #4 aclk = ~aclk;
    cwf_core #(.ADDR_W(5)) u_dut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .full_reset_n,
        .pointer_reset_n, .width_sel, .wr_en_n, .in_en_n, .din, .rd_en_n, .out_en_n, .dout,
        .dout_oe, .out_valid_n, .mark, .replay, .serial_clk, .serial_in, .serial_cfg_en_n,
        .empty_n, .almost_empty_n, .half_full_n, .almost_full_n, .full_n);
    cwf_writer u_wr (.aclk, .wr_en_n, .in_en_n, .din);
    function automatic cwf_word_t lanes(input logic [2:0] c);
        int w [8] = '{9, 12, 16, 18, 20, 24, 32, 36};
        return cwf_word_t'((37'h1 << w[c]) - 37'h1);
    endfunction : lanes
    task automatic chk(input cwf_word_t got, input cwf_word_t exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic done = 0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        for (int t = 0; !done && t < 50; t++) begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (bv) begin
                br <= 1'b0;
                done = 1;
                chk(bresp, r, "bresp");
            end
        end
        if (!done) begin
            n_mismatch++;
            $display("MISMATCH %0t bus write timed out", $time);
        end
        @(posedge aclk);
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] r);
        logic done = 0;
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        for (int t = 0; !done && t < 50; t++) begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
            if (rv) begin
                rr <= 1'b0;
                done = 1;
                chk({rresp, rdat & m}, {r, e}, "bus read");
            end
        end
        if (!done) begin
            n_mismatch++;
            $display("MISMATCH %0t bus read timed out", $time);
        end
        @(posedge aclk);
    endtask : axr
    task automatic rdw(input int n, input bit skip);
        for (int i = 0; i < n; i++) begin
            rd_en_n <= 1'b0;
            out_en_n <= skip && $urandom_range(1) == 1;
            @(posedge aclk);
        end
        rd_en_n <= 1'b1;
        out_en_n <= 1'b0;
        @(posedge aclk);
    endtask : rdw
    task automatic wait_n(input int n);
        repeat (n) @(posedge aclk);
    endtask : wait_n
    // reference pointers and memory, updated on the edges the core samples
    always @(posedge aclk) begin
        pend = 0;
        if (!aresetn || !full_reset_n || !pointer_reset_n) begin
            wp = 0;
            rp = 0;
            mk = 0;
            rl = 0;
        end else begin
            if (mark) mk = rl;
            wok = !wr_en_n && (wp - rp + dep) % dep < dep - 4;
            if (replay && !rp_q) rp = mk;
            else if (!rd_en_n && wp != rp) begin
                exp_q = mem[rp];
                rl = rp;
                pend = 1;
                ps = out_en_n;
                rp = (rp + 1) % dep;
            end
            if (wok) begin
                if (!in_en_n) mem[wp] = din & msk;
                wp = (wp + 1) % dep;
            end
        end
        rp_q = replay;
        cyc++;
        if (cyc == 8000) begin
            n_mismatch++;
            $display("MISMATCH %0t cycle limit reached", $time);
            final_report();
        end
    end
    always @(negedge aclk) begin
        if (pend) begin
            chk(out_valid_n, ps, "valid");
            chk(dout_oe, ps ? '0 : msk, "lanes");
            if (!ps) chk(dout, exp_q, "data");
        end
    end
    initial begin
        void'($urandom(91));
        msk = lanes(3'h0);
        af = 10'($urandom_range(27, 16));
        ae = 10'($urandom_range(12, 8));
        wait_n(20);
        aresetn <= 1'b1;
        full_reset_n <= 1'b1;
        wait_n(3);
        serial_cfg_en_n <= 1'b0;
        for (int i = 19; i >= 0; i--) begin
            serial_in <= 1'({af, ae} >> i);
            wait_n(2);
            serial_clk <= 1'b1;
            wait_n(2);
            serial_clk <= 1'b0;
        end
        serial_cfg_en_n <= 1'b1;
        axr(8'h08, 32'h3FF, 32'(af), 2'b00);
        axr(8'h04, 32'h3FF, 32'(ae), 2'b00);
        axr(8'h10, 32'hFFFFFFFF, 32'h0, 2'b10);
        ae = 10'($urandom_range(12, 8));
        axw(8'h04, 32'(ae), 2'b00);
        axw(8'h14, 32'h0, 2'b10);
        pointer_reset_n <= 1'b0;
        wait_n(1);
        pointer_reset_n <= 1'b1;
        axr(8'h04, 32'h3FF, 32'(ae), 2'b00);
        u_wr.burst(10, 0);
        wait_n(4);
        chk(almost_empty_n, 10 > ae, "almost empty");
        chk(almost_full_n, 10 < 32 - af, "almost full");
        rdw(3, 0);
        rdw(7, 1);
        u_wr.burst(24, 0);
        wait_n(3);
        rdw(24, 1);
        $display("offsets and flags test done");
        u_wr.burst(4, 0);
        wait_n(3);
        rdw(1, 0);
        mark <= 1'b1;
        wait_n(1);
        mark <= 1'b0;
        rdw(2, 0);
        wait_n(4);
        replay <= 1'b1;
        wait_n(1);
        replay <= 1'b0;
        wait_n(3);
        rdw(4, 0);
        wait_n(3);
        chk(empty_n, 0, "empty after replay");
        $display("mark and replay test done");
        for (int c = 0; c < 8; c++) begin
            full_reset_n <= 1'b0;
            width_sel <= 3'(c);
            wait_n(2);
            full_reset_n <= 1'b1;
            wait_n(1);
            width_sel <= 3'($urandom);
            dep = 32 >> (c == 0 ? 0 : c < 4 ? 1 : 2);
            msk = lanes(3'(c));
            u_wr.burst(dep - 4, c > 0);
            wait_n(3);
            chk({full_n, half_full_n}, 0, "full");
            u_wr.burst(2, 0);
            wait_n(3);
            axr(8'h0C, 32'hFFFFFFFF, 32'(dep - 4), 2'b00);
            axr(8'h00, 32'hE0, 32'(c) << 5, 2'b00);
            rdw(dep - 4, 1);
            wait_n(3);
            chk({empty_n, almost_empty_n}, 0, "drained");
        end
        $display("width test done");
        final_report();
    end
endmodule : tb
`default_nettype wire
